// file: pkg/cq_desc_pkg.sv
// Purpose: Constants and types for the completer request descriptor framer
// Assumes: Header fields arrive already parsed from the received request
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus
package cq_desc_pkg;

	// Descriptor field positions
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 63;
	localparam int CNT_LSB = 64;
	localparam int CNT_MSB = 74;
	localparam int TYPE_LSB = 75;
	localparam int TYPE_MSB = 78;
	localparam int RID_LSB = 80;
	localparam int RID_MSB = 95;
	localparam int TAG_LSB = 96;
	localparam int TAG_MSB = 103;
	localparam int FUNC_LSB = 104;
	localparam int FUNC_MSB = 111;
	localparam int BAR_LSB = 112;
	localparam int BAR_MSB = 114;
	localparam int APER_LSB = 115;
	localparam int APER_MSB = 120;
	localparam int TC_LSB = 121;
	localparam int TC_MSB = 123;
	localparam int ATTR_LSB = 124;
	localparam int ATTR_MSB = 126;
	localparam int SNOOP_LSB = 0;
	localparam int SNOOP_MSB = 15;
	localparam int NOSNOOP_LSB = 16;
	localparam int NOSNOOP_MSB = 31;
	localparam int OBFF_LSB = 32;
	localparam int OBFF_MSB = 35;
	localparam int DESC_W = 128;

	// Request type codes
	localparam logic [3:0] RT_MEM_RD = 4'h0;
	localparam logic [3:0] RT_MEM_WR = 4'h1;
	localparam logic [3:0] RT_IO_RD = 4'h2;
	localparam logic [3:0] RT_IO_WR = 4'h3;
	localparam logic [3:0] RT_FETCH_ADD = 4'h4;
	localparam logic [3:0] RT_SWAP = 4'h5;
	localparam logic [3:0] RT_CAS = 4'h6;
	localparam logic [3:0] RT_MSG = 4'hC;
	localparam logic [3:0] RT_MSG_VENDOR = 4'hD;
	localparam logic [3:0] RT_MSG_ATS = 4'hE;

	// Target function, BAR, count and OBFF codes
	localparam logic [7:0] FUNC_VF_BASE = 8'h40;
	localparam logic [2:0] BAR_ROM = 3'h6;
	localparam logic [2:0] BAR_NO_CHECK = 3'h7;
	localparam logic [10:0] CNT_ONE = 11'h001;
	localparam logic [3:0] OBFF_CPU_ACTIVE = 4'hF;
	localparam logic [3:0] OBFF_MEM_PATH = 4'h1;
	localparam logic [3:0] OBFF_IDLE = 4'h0;

	// Register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int CTRL_ARI_BIT = 0;
	localparam int STAT_CNT_LSB = 0;
	localparam int STAT_CNT_MSB = 15;
	localparam int STAT_TYPE_LSB = 16;
	localparam int STAT_TYPE_MSB = 19;
	localparam int STAT_OBFF_RSV_BIT = 20;

	typedef enum logic [3:0] {
		KIND_MEM_RD, KIND_MEM_WR, KIND_IO_RD, KIND_IO_WR, KIND_FETCH_ADD, KIND_SWAP,
		KIND_CAS, KIND_MSG_LTR, KIND_MSG_OBFF, KIND_MSG_OTHER, KIND_MSG_VENDOR, KIND_MSG_ATS
	} reqKind_t;

	typedef struct packed {
		reqKind_t kind;
		logic addr64;
		logic [61:0] dwAddr;
		logic [10:0] dwCount;
		logic zeroLen;
		logic [3:0] firstBe;
		logic [3:0] lastBe;
		logic [15:0] reqId;
		logic [7:0] tag;
		logic [2:0] tc;
		logic [2:0] attr;
		logic isVf;
		logic [2:0] funcIdx;
		logic [2:0] barId;
		logic barIs64;
		logic romHit;
		logic noBarCheck;
		logic [5:0] aperture;
		logic [5:0] vfCountLog2;
		logic [15:0] snoopLat;
		logic [15:0] noSnoopLat;
		logic [3:0] obffCode;
	} reqHdr_t;

	typedef struct packed {
		logic sop;
		logic [3:0] firstDwordByteEnables;
		logic [3:0] lastDwordByteEnables;
	} cqSideband_t;

endpackage : cq_desc_pkg

// file: hdl/completer_req_descriptor.sv
// Purpose: Frames each completer request as a 128-bit descriptor stream
// Assumes: Parsed header and BAR check result arrive with a valid/ready pair
// Notes: Only the descriptor is emitted; payload is joined elsewhere
`timescale 1ns/1ps
module completer_req_descriptor
	import cq_desc_pkg::*;
#(
	parameter int DATA_W = 128
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Parsed request in
	input wire reqHdr_t hdrIn,
	input wire logic hdrValid,
	output logic hdrReady,
	// Descriptor stream out
	output logic [DATA_W-1:0] descData,
	output logic [DATA_W/32-1:0] descKeep,
	output logic descValid,
	output logic descLast,
	input wire logic descReady,
	output cqSideband_t completerRequestSideband,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	localparam int KEEP_W = DATA_W / 32;

	if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256)
	begin : g_badWidth
		$error("DATA_W must be 64, 128 or 256");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} state_t;

	// Type code for each request kind
	function automatic logic [3:0] typeCode(input reqKind_t k);
		case (k)
			KIND_MEM_RD: typeCode = RT_MEM_RD;
			KIND_MEM_WR: typeCode = RT_MEM_WR;
			KIND_IO_RD: typeCode = RT_IO_RD;
			KIND_IO_WR: typeCode = RT_IO_WR;
			KIND_FETCH_ADD: typeCode = RT_FETCH_ADD;
			KIND_SWAP: typeCode = RT_SWAP;
			KIND_CAS: typeCode = RT_CAS;
			KIND_MSG_VENDOR: typeCode = RT_MSG_VENDOR;
			KIND_MSG_ATS: typeCode = RT_MSG_ATS;
			default: typeCode = RT_MSG;
		endcase
	endfunction : typeCode

	// Kind belongs to the memory, I/O and atomic format
	function automatic logic isAddrKind(input reqKind_t k);
		isAddrKind = (k inside {KIND_MEM_RD, KIND_MEM_WR, KIND_IO_RD, KIND_IO_WR,
			KIND_FETCH_ADD, KIND_SWAP, KIND_CAS});
	endfunction : isAddrKind

	// Kind is an I/O access
	function automatic logic isIoKind(input reqKind_t k);
		isIoKind = (k == KIND_IO_RD) || (k == KIND_IO_WR);
	endfunction : isIoKind

	state_t state_q, state_d;
	logic [DESC_W-1:0] desc_q;
	logic hdrReady_q;
	logic ariEn_q;
	logic obffRsv_q;
	logic [15:0] descCnt_q;
	logic [3:0] lastType_q;
	logic [DATA_W-1:0] descData_q;
	logic [KEEP_W-1:0] descKeep_q;
	logic descValid_q, descLast_q;
	cqSideband_t sideband_q;
	logic [31:0] wbDat_q;
	logic wbAck_q;

	// Field derivation from the incoming header
	wire logic accept = hdrValid && hdrReady_q;
	wire logic addrKind = isAddrKind(hdrIn.kind);
	wire logic ioKind = isIoKind(hdrIn.kind);
	wire logic memKind = (hdrIn.kind == KIND_MEM_RD) || (hdrIn.kind == KIND_MEM_WR);
	wire logic msgKind = !addrKind;
	wire logic zeroLenMem = memKind && hdrIn.zeroLen;
	wire logic [3:0] reqType = typeCode(hdrIn.kind);
	wire logic [61:0] dwAddr = hdrIn.addr64 ? hdrIn.dwAddr : {30'h0, hdrIn.dwAddr[29:0]};
	wire logic [10:0] dwCount = (ioKind || zeroLenMem) ? CNT_ONE : hdrIn.dwCount;
	wire logic [3:0] firstBe = zeroLenMem ? 4'h0 : hdrIn.firstBe;
	wire logic [7:0] funcRaw = hdrIn.isVf ? (FUNC_VF_BASE | {5'h00, hdrIn.funcIdx})
		: {5'h00, hdrIn.funcIdx};
	wire logic [7:0] targetFunc = ariEn_q ? funcRaw : {5'h00, funcRaw[2:0]};
	wire logic [2:0] barCode = hdrIn.noBarCheck ? BAR_NO_CHECK : hdrIn.romHit ? BAR_ROM
		: hdrIn.barIs64 ? {hdrIn.barId[2:1], 1'b0} : hdrIn.barId;
	wire logic apShrink = hdrIn.isVf && (hdrIn.aperture > hdrIn.vfCountLog2);
	wire logic [5:0] aperture = !hdrIn.isVf ? hdrIn.aperture
		: apShrink ? 6'(hdrIn.aperture - hdrIn.vfCountLog2) : 6'h00;
	wire logic [2:0] attr = {hdrIn.attr[2] && (memKind || msgKind), hdrIn.attr[1:0]};
	wire logic obffReserved = (hdrIn.kind == KIND_MSG_OBFF) && !(hdrIn.obffCode inside
		{OBFF_CPU_ACTIVE, OBFF_MEM_PATH, OBFF_IDLE});

	// Descriptor assembly
	logic [DESC_W-1:0] descNext;
	always_comb
	begin
		descNext = '0;
		descNext[CNT_MSB:CNT_LSB] = dwCount;
		descNext[TYPE_MSB:TYPE_LSB] = reqType;
		descNext[RID_MSB:RID_LSB] = hdrIn.reqId;
		descNext[TAG_MSB:TAG_LSB] = hdrIn.tag;
		descNext[TC_MSB:TC_LSB] = hdrIn.tc;
		descNext[ATTR_MSB:ATTR_LSB] = attr;
		if (addrKind)
		begin
			descNext[ADDR_MSB:ADDR_LSB] = dwAddr;
			descNext[FUNC_MSB:FUNC_LSB] = targetFunc;
			descNext[BAR_MSB:BAR_LSB] = barCode;
			descNext[APER_MSB:APER_LSB] = aperture;
		end
		else if (hdrIn.kind == KIND_MSG_LTR)
		begin
			descNext[SNOOP_MSB:SNOOP_LSB] = hdrIn.snoopLat;
			descNext[NOSNOOP_MSB:NOSNOOP_LSB] = hdrIn.noSnoopLat;
		end
		else if (hdrIn.kind == KIND_MSG_OBFF)
		begin
			descNext[OBFF_MSB:OBFF_LSB] = hdrIn.obffCode;
		end
	end

	// Beat sequencing
	wire logic beatDone = descValid_q && descReady;
	wire logic twoBeats = (DATA_W == 64);
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (accept) state_d = ST_LOW;
			ST_LOW: if (beatDone) state_d = twoBeats ? ST_HIGH : ST_IDLE;
			ST_HIGH: if (beatDone) state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	wire logic [DATA_W-1:0] highBeat = DATA_W'(desc_q[DESC_W-1:DESC_W/2]);
	wire logic [KEEP_W-1:0] descKeepVal = KEEP_W'(4'hF);

	// Stream registers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			desc_q <= '0;
			hdrReady_q <= 1'b0;
			descData_q <= '0;
			descKeep_q <= '0;
			descValid_q <= 1'b0;
			descLast_q <= 1'b0;
			sideband_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			hdrReady_q <= (state_d == ST_IDLE) && !accept;
			if (accept)
			begin
				desc_q <= descNext;
				descData_q <= DATA_W'(descNext);
				descKeep_q <= descKeepVal;
				descValid_q <= 1'b1;
				descLast_q <= !twoBeats;
				sideband_q <= '{sop: 1'b1, firstDwordByteEnables: firstBe,
					lastDwordByteEnables: hdrIn.lastBe};
			end
			else if (beatDone && state_q == ST_LOW && twoBeats)
			begin
				descData_q <= highBeat;
				descLast_q <= 1'b1;
				sideband_q.sop <= 1'b0;
			end
			else if (beatDone)
			begin
				descValid_q <= 1'b0;
				descLast_q <= 1'b0;
				sideband_q <= '0;
			end
		end
	end

	// Wishbone decode
	wire logic wbReq = wb_cyc_i && wb_stb_i && !wbAck_q;
	// Writes land on the edge that sees ack high, while the master still holds them
	wire logic wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && wbAck_q;
	wire logic hitCtrl = (wb_adr_i == REG_CTRL);
	wire logic hitStatus = (wb_adr_i == REG_STATUS);
	wire logic rsvClear = wbWrite && hitStatus && wb_sel_i[2] && wb_dat_i[STAT_OBFF_RSV_BIT];
	wire logic [31:0] statusWord = {11'h000, obffRsv_q, lastType_q, descCnt_q};
	wire logic [31:0] readWord = hitCtrl ? {31'h0, ariEn_q} : hitStatus ? statusWord : 32'h0;

	// Register file and bus answer
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ariEn_q <= 1'b0;
			obffRsv_q <= 1'b0;
			descCnt_q <= '0;
			lastType_q <= '0;
			wbAck_q <= 1'b0;
			wbDat_q <= '0;
		end
		else
		begin
			wbAck_q <= wbReq;
			wbDat_q <= wbReq ? readWord : 32'h0;
			if (wbWrite && hitCtrl && wb_sel_i[0])
				ariEn_q <= wb_dat_i[CTRL_ARI_BIT];
			// Set wins over clear
			obffRsv_q <= (accept && obffReserved) || (obffRsv_q && !rsvClear);
			if (accept)
			begin
				descCnt_q <= descCnt_q + 16'h0001;
				lastType_q <= reqType;
			end
		end
	end

	assign hdrReady = hdrReady_q;
	assign descData = descData_q;
	assign descKeep = descKeep_q;
	assign descValid = descValid_q;
	assign descLast = descLast_q;
	assign completerRequestSideband = sideband_q;
	assign wb_dat_o = wbDat_q;
	assign wb_ack_o = wbAck_q;

	// Descriptor checks
	AST_IO_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isIoKind(hdrIn.kind) |=> desc_q[CNT_MSB:CNT_LSB] == CNT_ONE)
		else $error("I/O count not one");
	AST_ADDR32: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && !hdrIn.addr64 |=> desc_q[63:32] == 32'h0)
		else $error("Upper address not cleared");
	AST_ZERO_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && hdrIn.zeroLen && hdrIn.kind == KIND_MEM_WR
		|=> desc_q[CNT_MSB:CNT_LSB] == CNT_ONE
		&& completerRequestSideband.firstDwordByteEnables == 4'h0)
		else $error("Zero length not reported");
	AST_TYPE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept |=> desc_q[TYPE_MSB:TYPE_LSB] == typeCode($past(hdrIn.kind)) && descValid)
		else $error("Request type wrong");
	AST_BAR64: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && hdrIn.barIs64 && !hdrIn.romHit && !hdrIn.noBarCheck
		|=> desc_q[BAR_LSB] == 1'b0)
		else $error("64-bit BAR not lower");
	AST_IDO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && !memKind |=> !desc_q[ATTR_MSB])
		else $error("Ordering bit on wrong kind");
	AST_ARI_FUNC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && !ariEn_q |=> desc_q[FUNC_MSB:FUNC_LSB+3] == 5'h00)
		else $error("Upper function bits set");
	AST_TAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept |=> desc_q[TAG_MSB:TAG_LSB] == $past(hdrIn.tag))
		else $error("Tag not passed");
	AST_BEATS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		beatDone && completerRequestSideband.sop |=> descValid == twoBeats && (descLast || !twoBeats))
		else $error("Beat count wrong");

	// Field pass-through checks
	AST_ADDR_PASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && hdrIn.addr64
		|=> desc_q[ADDR_MSB:ADDR_LSB] == $past(hdrIn.dwAddr))
		else $error("Dword address not passed");
	AST_COUNT_PASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && memKind && !hdrIn.zeroLen |=> desc_q[CNT_MSB:CNT_LSB] == $past(hdrIn.dwCount))
		else $error("Dword count not passed");
	AST_RID: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept |=> desc_q[RID_MSB:RID_LSB] == $past(hdrIn.reqId))
		else $error("Requester ID not passed");
	AST_ARI_RID: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && ariEn_q |=> desc_q[RID_MSB:RID_LSB] == $past(hdrIn.reqId))
		else $error("Requester ID altered with ARI");
	AST_VF_FUNC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && hdrIn.isVf && ariEn_q
		|=> desc_q[FUNC_MSB:FUNC_LSB] == (FUNC_VF_BASE | 8'($past(hdrIn.funcIdx))))
		else $error("Virtual function number wrong");
	AST_BAR_NOCHK: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && hdrIn.noBarCheck
		|=> desc_q[BAR_MSB:BAR_LSB] == BAR_NO_CHECK)
		else $error("No-check BAR code wrong");
	AST_BAR_ROM: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && hdrIn.romHit && !hdrIn.noBarCheck
		|=> desc_q[BAR_MSB:BAR_LSB] == BAR_ROM)
		else $error("ROM BAR code wrong");
	AST_APER: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && !hdrIn.isVf
		|=> desc_q[APER_MSB:APER_LSB] == $past(hdrIn.aperture))
		else $error("Aperture not passed");
	AST_VF_APER: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && isAddrKind(hdrIn.kind) && hdrIn.isVf && hdrIn.aperture > hdrIn.vfCountLog2
		|=> desc_q[APER_MSB:APER_LSB] == 6'($past(hdrIn.aperture) - $past(hdrIn.vfCountLog2)))
		else $error("Virtual aperture wrong");
	AST_TC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept |=> desc_q[TC_MSB:TC_LSB] == $past(hdrIn.tc))
		else $error("Traffic class not passed");
	AST_LTR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && hdrIn.kind == KIND_MSG_LTR
		|=> desc_q[NOSNOOP_MSB:SNOOP_LSB] == {$past(hdrIn.noSnoopLat), $past(hdrIn.snoopLat)})
		else $error("Latency values wrong");
	AST_OBFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && hdrIn.kind == KIND_MSG_OBFF |=> desc_q[OBFF_MSB:OBFF_LSB] == $past(hdrIn.obffCode))
		else $error("Hint code not passed");
	AST_MSG_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept && !isAddrKind(hdrIn.kind) |=> desc_q[APER_MSB:FUNC_LSB] == 17'h00000)
		else $error("Message descriptor has stray bits");
	AST_SPARE_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept |=> !desc_q[DESC_W-1] && !desc_q[TYPE_MSB+1])
		else $error("Spare descriptor bit set");

	// Stream handshake checks
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		descValid_q && !descReady |=> descValid_q && $stable(descData_q))
		else $error("Beat changed before taken");
	AST_ONE_PENDING: assert property (@(posedge clk_sys) disable iff (!rst_n)
		descValid_q |-> !hdrReady_q)
		else $error("Ready while descriptor pending");

endmodule : completer_req_descriptor

// file: dv/cq_user_model.sv
// Purpose: User-side consumer of completer request descriptors
// Assumes: One 128-bit beat per descriptor
// Notes: Ready stays low for stallCycles+1 cycles of each offered beat
`timescale 1ns/1ps
module cq_user_model
	import cq_desc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Descriptor stream
	input wire logic [127:0] descData,
	input wire logic [3:0] descKeep,
	input wire logic descValid,
	input wire logic descLast,
	output logic descReady,
	input wire cqSideband_t completerRequestSideband,
	// Bench view
	input wire logic [3:0] stallCycles,
	output logic [127:0] seenDesc,
	output cqSideband_t seenSb,
	output logic [4:0] seenEnd,
	output logic [63:0] byteAddr,
	output logic [29:0] keptFields,
	output logic [7:0] beats
);
	logic [3:0] waitCnt;
	logic [29:0] keptFields_q;
	logic [1:0] beOffset;
	assign beOffset = seenSb.firstDwordByteEnables[0] ? 2'h0 :
		seenSb.firstDwordByteEnables[1] ? 2'h1 : seenSb.firstDwordByteEnables[2] ? 2'h2 : 2'h3;
	assign byteAddr = {seenDesc[63:2], beOffset};
	assign keptFields = keptFields_q;
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			descReady <= 1'b0;
			waitCnt <= 4'h0;
			beats <= 8'h00;
		end
		else if (descValid && descReady)
		begin
			descReady <= 1'b0;
			waitCnt <= 4'h0;
			seenDesc <= descData;
			seenSb <= completerRequestSideband;
			seenEnd <= {descLast, descKeep};
			keptFields_q <= {descData[126:121], descData[103:80]};
			beats <= beats + 8'h01;
		end
		else if (descValid && waitCnt >= stallCycles)
			descReady <= 1'b1;
		else if (descValid)
			waitCnt <= waitCnt + 4'h1;
	end
endmodule : cq_user_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the completer request descriptor framer
// Assumes: 128-bit stream, one descriptor beat per request
// Notes: Expected descriptors are assembled field by field in the bench
`timescale 1ns/1ps
module testbench;
	import cq_desc_pkg::*;
	localparam logic [15:0] RID = 16'hA5C3;
	localparam logic [7:0] TAG = 8'h5A;
	localparam logic [2:0] TC = 3'h5;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	reqHdr_t hdrIn = '0;
	logic hdrValid = 1'b0;
	logic hdrReady, descValid, descLast, descReady, wb_ack_o;
	logic [127:0] descData, seenDesc;
	logic [3:0] descKeep;
	cqSideband_t completerRequestSideband, seenSb;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, stallCycles = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [4:0] seenEnd;
	logic [63:0] byteAddr;
	logic [29:0] kept;
	logic [7:0] beats;
	logic [3:0] codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hC, 4'hC, 4'hC,
		4'hD, 4'hE};
	reqHdr_t h;
	int fails = 0;
	int comparisons = 0;
	// Free-running system clock
	always #10 clk_sys = ~clk_sys;
	completer_req_descriptor #(.DATA_W(128)) completer_req_descriptor_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .hdrIn(hdrIn), .hdrValid(hdrValid), .hdrReady(hdrReady),
		.descData(descData), .descKeep(descKeep), .descValid(descValid), .descLast(descLast),
		.descReady(descReady), .completerRequestSideband(completerRequestSideband),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	cq_user_model cq_user_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .descData(descData),
		.descKeep(descKeep), .descValid(descValid), .descLast(descLast), .descReady(descReady),
		.completerRequestSideband(completerRequestSideband), .stallCycles(stallCycles),
		.seenDesc(seenDesc), .seenSb(seenSb), .seenEnd(seenEnd), .byteAddr(byteAddr),
		.keptFields(kept), .beats(beats));
	task automatic final_report();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic check(string n, logic [127:0] s, logic [127:0] e);
		comparisons++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic timeout(int n, int lim);
		if (n >= lim)
		begin
			fails++;
			final_report();
		end
	endtask : timeout
	// Offer one header and wait until its descriptor is consumed
	task automatic send(reqHdr_t r);
		int n;
		logic [7:0] b0;
		n = 0;
		b0 = beats;
		hdrIn <= r;
		hdrValid <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (hdrReady !== 1'b1 && n < 400);
		hdrValid <= 1'b0;
		while (beats === b0 && n < 400)
		begin
			@(posedge clk_sys);
			n++;
		end
		timeout(n, 400);
	endtask : send
	// Classic Wishbone single cycle
	task automatic wb(logic we, logic [3:0] a, logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_sys);
		timeout(n, 50);
	endtask : wb
	function automatic reqHdr_t base(reqKind_t k);
		reqHdr_t r;
		r = '0;
		r.kind = k;
		r.addr64 = 1'b1;
		r.dwAddr = 62'h1234_5678_9ABC_DEF0;
		r.dwCount = 11'h100;
		r.reqId = RID;
		r.tag = TAG;
		r.tc = TC;
		r.attr = 3'h7;
		r.funcIdx = 3'h1;
		r.barId = 3'h1;
		r.aperture = 6'h0C;
		return r;
	endfunction : base
	function automatic logic [127:0] mk(logic [61:0] a, logic [10:0] c, logic [3:0] t,
		logic [7:0] f, logic [2:0] b, logic [5:0] ap, logic [2:0] at);
		return {1'b0, at, TC, ap, b, f, TAG, RID, 1'b0, t, c, a, 2'b00};
	endfunction : mk
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		wb(1'b0, REG_STATUS, 32'h0, q);
		check("status reset", q, 32'h0);
		wb(1'b0, 4'hC, 32'h0, q);
		check("unmapped", q, 32'h0);
		for (int k = 0; k < 12; k++)
		begin
			send(base(reqKind_t'(k)));
			check("type", seenDesc[78:75], codes[k]);
			check("end", {seenSb.sop, seenEnd}, 6'h3F);
		end
		wb(1'b0, REG_STATUS, 32'h0, q);
		check("status", q, 32'h000E_000C);
		h = base(KIND_MEM_RD);
		h.firstBe = 4'h4;
		h.lastBe = 4'hC;
		send(h);
		check("mem", seenDesc, mk(h.dwAddr, 11'h100, RT_MEM_RD, 8'h01, 3'h1, 6'h0C, 3'h7));
		check("byte addr", byteAddr, {h.dwAddr, 2'b10});
		check("last be", seenSb.lastDwordByteEnables, 4'hC);
		check("kept", kept, {3'h7, TC, TAG, RID});
		stallCycles <= 4'h3;
		h = base(KIND_MEM_WR);
		h.addr64 = 1'b0;
		h.zeroLen = 1'b1;
		h.firstBe = 4'hF;
		send(h);
		check("zero", seenDesc, mk({32'h0, h.dwAddr[29:0]}, 11'h001, RT_MEM_WR, 8'h01, 3'h1,
			6'h0C, 3'h7));
		check("zero be", seenSb.firstDwordByteEnables, 4'h0);
		stallCycles <= 4'h0;
		h = base(KIND_IO_WR);
		h.dwCount = 11'h005;
		send(h);
		check("io", seenDesc, mk(h.dwAddr, 11'h001, RT_IO_WR, 8'h01, 3'h1, 6'h0C, 3'h3));
		wb(1'b1, REG_CTRL, 32'h1, q);
		wb(1'b0, REG_CTRL, 32'h0, q);
		check("ctrl", q, 32'h1);
		h = base(KIND_MEM_WR);
		h.isVf = 1'b1;
		h.funcIdx = 3'h2;
		h.barId = 3'h3;
		h.barIs64 = 1'b1;
		h.aperture = 6'h14;
		h.vfCountLog2 = 6'h03;
		send(h);
		check("vf", seenDesc[120:104], {6'h11, 3'h2, 8'h42});
		wb(1'b1, REG_CTRL, 32'h0, q);
		send(h);
		check("no ari", seenDesc[111:104], 8'h02);
		h = base(KIND_MEM_RD);
		h.romHit = 1'b1;
		send(h);
		check("rom", seenDesc[114:112], BAR_ROM);
		h.noBarCheck = 1'b1;
		send(h);
		check("no check", seenDesc[114:112], BAR_NO_CHECK);
		h = base(KIND_MSG_LTR);
		h.snoopLat = 16'h1234;
		h.noSnoopLat = 16'hBEEF;
		send(h);
		check("ltr", seenDesc, mk(62'h0, 11'h100, RT_MSG, 8'h00, 3'h0, 6'h00, 3'h7)
			| 128'hBEEF_1234);
		h = base(KIND_MSG_OBFF);
		h.obffCode = OBFF_CPU_ACTIVE;
		send(h);
		check("obff", seenDesc[35:32], OBFF_CPU_ACTIVE);
		h.obffCode = 4'h5;
		send(h);
		check("obff rsv", seenDesc[35:32], 4'h5);
		wb(1'b0, REG_STATUS, 32'h0, q);
		check("rsv seen", q[20], 1'b1);
		wb(1'b1, REG_STATUS, 32'h0010_0000, q);
		wb(1'b0, REG_STATUS, 32'h0, q);
		check("rsv clear", q[20], 1'b0);
		// Mid-run reset clears counters, then traffic resumes
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		wb(1'b0, REG_STATUS, 32'h0, q);
		check("status after reset", q, 32'h0);
		send(base(KIND_IO_RD));
		check("type after reset", seenDesc[78:75], RT_IO_RD);
		final_report();
	end
endmodule : testbench
